// *** bench/boot_program_card_loader_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module boot_program_card_loader_tb;
  import bpcl_pkg::*;
  localparam int BC = 4;
  logic       clk = 0;
  logic       srst = 1;
  logic       present = 0;
  logic [1:0] kind = 2'h0;
  logic       mrst = 0;
  logic       load = 0;
  logic       prog = 0;
  logic [2:0] lat = 3'h0;
  logic       has_prog;
  logic       done;
  bpcl_out_s  o;
  int         seed = 32'h3c96;
  int         fail_count = 0;
  int         compares = 0;
  always #20 clk = ~clk;
  bpcl_loader #(.FLASH_CYCLES(40), .BLINK_CYCLES(BC)) i_dut (.sys_clk_i(clk), .srst_i(srst),
    .card_present_i(present), .card_kind_i(kind), .mem_reset_cmd_i(mrst), .store_has_prog_i(has_prog),
    .store_op_done_i(done), .stopped_led_o(o.stopped_led), .maintenance_indicator_o(o.maintenance_indicator),
    .run_from_store_o(o.run_from_store), .run_from_card_o(o.run_from_card), .erase_req_o(o.erase_req),
    .copy_to_card_req_o(o.copy_to_card_req), .copy_to_store_req_o(o.copy_to_store_req));
  bpcl_store_model i_store (.clk_i(clk), .load_i(load), .prog_i(prog), .lat_i(lat), .erase_i(o.erase_req),
    .to_card_i(o.copy_to_card_req), .to_store_i(o.copy_to_store_req), .has_prog_o(has_prog), .done_o(done));
  task automatic chk(input string n, input logic [6:0] s, input logic [6:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // power cycle; ld rewrites the store, otherwise it keeps its content
  task automatic boot(input logic p, input logic [1:0] k, input logic ld, input logic full);
    present = p;
    kind = k;
    load = ld;
    prog = full;
    lat = 3'($random(seed));
    srst = 1;
    step(1);
    load = 0;
    step(5);
    srst = 0;
  endtask
  task automatic wait_pat(input string n, input logic [6:0] m, input logic [6:0] v);
    for (int i = 0; i < 60 && (o & m) !== v; i++)
      step(1);
    chk(n, o & m, v);
  endtask
  task automatic flash(input string n, input logic steady);
    int t;
    logic pm;
    t = 0;
    for (int i = 0; i < 2 * BC + 1; i++) begin
      pm = o.maintenance_indicator;
      step(1);
      t += int'(o.maintenance_indicator !== pm);
      chk(n, {1'b0, o.stopped_led, o[4:0]}, {1'b0, steady | o.maintenance_indicator, 5'h0});
    end
    chk({n, " blink"}, 7'(t >= 2), 7'h1);
  endtask
  // memory-reset command held three cycles for the synchroniser
  task automatic mreset;
    mrst = 1;
    step(3);
    mrst = 0;
  endtask
  function automatic logic [6:0] decide(input logic p, input logic [1:0] k, input logic full);
    if (!p)
      return full ? 7'h10 : 7'h00;
    if (k == BPCL_CARD_PROGRAM)
      return full ? 7'h04 : 7'h08;
    if (k == BPCL_CARD_TRANSFER)
      return full ? 7'h04 : 7'h01;
    if (k == BPCL_CARD_EMPTY)
      return full ? 7'h02 : 7'h00;
    // reserved kind: nothing to run, nothing touched
    return 7'h00;
  endfunction
  task automatic test_done;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #(40 * 5000);
    fail_count++;
    test_done;
  end
  initial begin
    step(1);
    // last two rounds present the reserved card kind
    for (int i = 0; i < 10; i++) begin
      boot(i > 1, 2'((i >> 1) - 1), 1, i[0]);
      // decision stands from the fourth edge; a fast done may end it two edges later
      step(4);
      chk("decision", o & 7'h1f, decide(i > 1, 2'((i >> 1) - 1), i[0]));
    end
    $display("test decision table done");
    boot(1, BPCL_CARD_PROGRAM, 1, 1);
    wait_pat("prog erase", 7'h7f, 7'h44);
    wait_pat("prog halt", 7'h1f, 7'h00);
    flash("prog halt", 0);
    step(20);
    flash("still halted", 0);
    mreset;
    wait_pat("run card", 7'h7f, 7'h08);
    boot(1, BPCL_CARD_PROGRAM, 0, 0);
    wait_pat("run card again", 7'h7f, 7'h08);
    present = 0;
    wait_pat("card removed", 7'h7f, 7'h40);
    chk("store after removal", 7'(has_prog), 7'h0);
    $display("test program card done");
    boot(1, BPCL_CARD_EMPTY, 1, 1);
    wait_pat("copy out", 7'h7f, 7'h42);
    wait_pat("erase after copy", 7'h7f, 7'h44);
    wait_pat("empty halt", 7'h1f, 7'h00);
    flash("empty halt", 0);
    kind = BPCL_CARD_PROGRAM;
    mreset;
    wait_pat("run copied card", 7'h7f, 7'h08);
    $display("test empty card done");
    boot(1, BPCL_CARD_TRANSFER, 1, 1);
    wait_pat("xfer erase", 7'h7f, 7'h44);
    wait_pat("xfer halt", 7'h1f, 7'h00);
    flash("xfer erased", 0);
    mreset;
    wait_pat("copy in", 7'h7f, 7'h41);
    wait_pat("copied halt", 7'h1f, 7'h00);
    flash("copied halt", 1);
    // card pulled before the power cycle
    boot(0, BPCL_CARD_EMPTY, 0, 0);
    wait_pat("run store", 7'h7f, 7'h10);
    $display("test transfer card done");
    boot(0, BPCL_CARD_EMPTY, 1, 0);
    step(6);
    flash("empty store", 0);
    wait_pat("flash over", 7'h7f, 7'h40);
    $display("test empty store done");
    test_done;
  end
endmodule
`default_nettype wire

// *** bench/bpcl_store_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module bpcl_store_model (
  input  wire logic       clk_i,
  input  wire logic       load_i,
  input  wire logic       prog_i,
  input  wire logic [2:0] lat_i,
  input  wire logic       erase_i,
  input  wire logic       to_card_i,
  input  wire logic       to_store_i,
  output logic            has_prog_o,
  output logic            done_o
);
  logic [2:0] cnt = 3'h0;
  initial has_prog_o = 1'b0;
  initial done_o = 1'b0;
  // content kept across srst, so a power cycle sees what the last run left
  always @(posedge clk_i) begin
    // a reload at power cycle wins over a request that the reset cuts short
    if (load_i) begin
      has_prog_o <= prog_i;
      done_o <= 1'b0;
      cnt <= 3'h0;
    end else if (done_o || !(erase_i || to_card_i || to_store_i)) begin
      done_o <= 1'b0;
      cnt <= 3'h0;
    end else if (cnt == lat_i) begin
      done_o <= 1'b1;
      if (erase_i)
        has_prog_o <= 1'b0;
      if (to_store_i)
        has_prog_o <= 1'b1;
    end else begin
      cnt <= cnt + 3'h1;
    end
  end
endmodule
`default_nettype wire

// *** hw/bpcl_loader.sv ***
`timescale 1ns/1ps
`default_nettype none
module bpcl_loader
  import bpcl_pkg::*;
#(
  parameter int unsigned FLASH_CYCLES = FLASH_CYC,
  parameter int unsigned BLINK_CYCLES = BLINK_CYC
) (
  input  wire logic       sys_clk_i,
  input  wire logic       srst_i,
  input  wire logic       card_present_i,
  input  wire logic [1:0] card_kind_i,
  input  wire logic       mem_reset_cmd_i,
  input  wire logic       store_has_prog_i,
  input  wire logic       store_op_done_i,
  output logic            stopped_led_o,
  output logic            maintenance_indicator_o,
  output logic            run_from_store_o,
  output logic            run_from_card_o,
  output logic            erase_req_o,
  output logic            copy_to_card_req_o,
  output logic            copy_to_store_req_o
);

  typedef struct packed {
    logic             card_s1;
    logic             card_s2;
    logic [1:0]       kind_s1;
    logic [1:0]       kind_s2;
    logic             cmd_s1;
    logic             cmd_s2;
    logic             cmd_s3;
    bpcl_state_e      state;
    logic [1:0]       settle;
    logic [CNT_W-1:0] timer;
    logic [CNT_W-1:0] blink_cnt;
    logic             blink;
    bpcl_out_s        outs;
  } bpcl_regs_s;

  bpcl_regs_s r;
  bpcl_regs_s next_r;
  logic       cmd_pulse;

  // outputs follow the state being entered, so every pin is a flop
  function automatic bpcl_out_s out_for(input bpcl_state_e st, input logic blk);
    bpcl_out_s o;
    o = '0;
    case (st)
      ST_HALT_ERASED, ST_EMPTY_FLASH: begin
        o.stopped_led           = blk;
        o.maintenance_indicator = blk;
      end
      ST_HALT_XFER: begin
        o.stopped_led           = 1'b1;
        o.maintenance_indicator = blk;
      end
      ST_RUN_STORE: o.run_from_store = 1'b1;
      ST_RUN_CARD:  o.run_from_card  = 1'b1;
      ST_ERASE: begin
        o.stopped_led = 1'b1;
        o.erase_req   = 1'b1;
      end
      ST_COPY_OUT: begin
        o.stopped_led      = 1'b1;
        o.copy_to_card_req = 1'b1;
      end
      ST_COPY_IN: begin
        o.stopped_led       = 1'b1;
        o.copy_to_store_req = 1'b1;
      end
      default: o.stopped_led = 1'b1;
    endcase
    return o;
  endfunction

  function automatic logic kind_is(input logic [1:0] k, input bpcl_card_e want);
    return k == want;
  endfunction

  assign cmd_pulse = r.cmd_s2 & ~r.cmd_s3;

  always_comb begin
    next_r         = r;
    next_r.card_s1 = card_present_i;
    next_r.card_s2 = r.card_s1;
    next_r.kind_s1 = card_kind_i;
    next_r.kind_s2 = r.kind_s1;
    next_r.cmd_s1  = mem_reset_cmd_i;
    next_r.cmd_s2  = r.cmd_s1;
    next_r.cmd_s3  = r.cmd_s2;
    if (r.blink_cnt == CNT_W'(BLINK_CYCLES - 1)) begin
      next_r.blink_cnt = '0;
      next_r.blink     = ~r.blink;
    end else begin
      next_r.blink_cnt = r.blink_cnt + CNT_W'(1);
    end
    case (r.state)
      ST_SETTLE: begin
        next_r.settle = r.settle + 2'h1;
        if (r.settle == SETTLE_LAST) begin
          next_r.state = ST_EVAL;
        end
      end
      ST_EVAL: begin
        next_r.timer = '0;
        if (!r.card_s2) begin
          if (store_has_prog_i) begin
            next_r.state = ST_RUN_STORE;
          end else begin
            next_r.state = ST_EMPTY_FLASH;
          end
        end else if (kind_is(r.kind_s2, BPCL_CARD_PROGRAM)) begin
          next_r.state = store_has_prog_i ? ST_ERASE : ST_RUN_CARD;
        end else if (kind_is(r.kind_s2, BPCL_CARD_TRANSFER)) begin
          next_r.state = store_has_prog_i ? ST_ERASE : ST_COPY_IN;
        end else if (kind_is(r.kind_s2, BPCL_CARD_EMPTY)) begin
          // save store contents to the card first
          next_r.state = store_has_prog_i ? ST_COPY_OUT : ST_NO_PROG;
        end else begin
          next_r.state = ST_NO_PROG;
        end
      end
      ST_COPY_OUT: begin
        // erase only after card copy completes
        if (store_op_done_i) begin
          next_r.state = ST_ERASE;
        end
      end
      ST_ERASE: begin
        if (store_op_done_i) begin
          next_r.state = ST_HALT_ERASED;
        end
      end
      ST_COPY_IN: begin
        if (store_op_done_i) begin
          next_r.state = ST_HALT_XFER;
        end
      end
      ST_RUN_CARD: begin
        // card gone leaves nothing to run
        if (!r.card_s2) begin
          next_r.state = ST_NO_PROG;
        end else if (cmd_pulse) begin
          next_r.state  = ST_SETTLE;
          next_r.settle = '0;
        end
      end
      ST_EMPTY_FLASH: begin
        next_r.timer = r.timer + CNT_W'(1);
        if (r.timer == CNT_W'(FLASH_CYCLES - 1)) begin
          next_r.state = ST_NO_PROG;
        end
      end
      default: begin
        // halts leave only on memory reset
        if (cmd_pulse) begin
          next_r.state  = ST_SETTLE;
          next_r.settle = '0;
        end
      end
    endcase
    next_r.outs = out_for(next_r.state, next_r.blink);
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      r       <= '0;
      r.state <= ST_SETTLE;
      r.outs  <= out_for(ST_SETTLE, 1'b0);
    end else begin
      r <= next_r;
    end
  end

  assign stopped_led_o           = r.outs.stopped_led;
  assign maintenance_indicator_o = r.outs.maintenance_indicator;
  assign run_from_store_o        = r.outs.run_from_store;
  assign run_from_card_o         = r.outs.run_from_card;
  assign erase_req_o             = r.outs.erase_req;
  assign copy_to_card_req_o      = r.outs.copy_to_card_req;
  assign copy_to_store_req_o     = r.outs.copy_to_store_req;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  sequence seq_eval_card(bpcl_card_e k);
    r.state == ST_EVAL && r.card_s2 && r.kind_s2 == k && store_has_prog_i;
  endsequence

  sequence seq_card_copy_done;
    copy_to_card_req_o && store_op_done_i;
  endsequence

  a_empty_flash_leds: assert property (r.state == ST_EMPTY_FLASH |->
    stopped_led_o == r.blink && maintenance_indicator_o == r.blink)
    else $error("empty store flash pattern wrong");
  a_empty_flash_end: assert property (
    r.state == ST_EMPTY_FLASH && r.timer == CNT_W'(FLASH_CYCLES - 1) |=> r.state == ST_NO_PROG
    && !maintenance_indicator_o)
    else $error("empty store flash did not end on time");
  a_prog_card_erase: assert property (seq_eval_card(BPCL_CARD_PROGRAM) |=>
    erase_req_o && !run_from_card_o && !run_from_store_o)
    else $error("program card did not erase store");
  a_erase_held: assert property (erase_req_o && !store_op_done_i |=>
    erase_req_o && !run_from_card_o)
    else $error("erase request dropped before done");
  a_halt_holds: assert property (
    r.state == ST_HALT_ERASED && !cmd_pulse |=> r.state == ST_HALT_ERASED && !run_from_store_o
    && !run_from_card_o)
    else $error("left halt without reset command");
  a_card_run: assert property (
    r.state == ST_EVAL && r.card_s2 && r.kind_s2 == BPCL_CARD_PROGRAM && !store_has_prog_i
    |=> run_from_card_o && !run_from_store_o)
    else $error("program card not used for execution");
  a_copy_first: assert property (seq_eval_card(BPCL_CARD_EMPTY) |=>
    copy_to_card_req_o && !erase_req_o)
    else $error("empty card not written before erase");
  a_copy_out_held: assert property (copy_to_card_req_o && !store_op_done_i |=>
    copy_to_card_req_o && !erase_req_o)
    else $error("card copy request dropped before done");
  a_copy_then_erase: assert property (seq_card_copy_done |=>
    erase_req_o && !copy_to_card_req_o)
    else $error("erase did not follow card copy");
  a_xfer_erase: assert property (seq_eval_card(BPCL_CARD_TRANSFER) |=>
    erase_req_o && stopped_led_o && !copy_to_store_req_o)
    else $error("transfer card did not erase store");
  a_xfer_halt_leds: assert property (
    copy_to_store_req_o && store_op_done_i |=> stopped_led_o && maintenance_indicator_o == r.blink
    && !run_from_store_o)
    else $error("transfer halt pattern wrong");
  a_store_run: assert property (
    r.state == ST_EVAL && !r.card_s2 && store_has_prog_i |=> run_from_store_o && !erase_req_o
    && !stopped_led_o)
    else $error("store program not started");
  a_card_removed: assert property (run_from_card_o && !r.card_s2 |=>
    !run_from_card_o && !run_from_store_o)
    else $error("still running after card removal");

endmodule
`default_nettype wire

// *** hw/bpcl_pkg.sv ***
`default_nettype none
package bpcl_pkg;

  // clock rate and printed figures
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned CLK_PER_MS    = CLK_HZ / 1000;
  localparam int unsigned FLASH_TIME_MS = 3000;
  localparam int unsigned BLINK_HALF_MS = 250;
  localparam int unsigned FLASH_CYC     = FLASH_TIME_MS * CLK_PER_MS;
  localparam int unsigned BLINK_CYC     = BLINK_HALF_MS * CLK_PER_MS;

  // cycles after reset before card pins are trusted (sync depth + 1)
  localparam logic [1:0] SETTLE_LAST = 2'h2;

  localparam int unsigned CNT_W = 32;

  typedef enum logic [1:0] {
    BPCL_CARD_EMPTY    = 2'h0,
    BPCL_CARD_PROGRAM  = 2'h1,
    BPCL_CARD_TRANSFER = 2'h2
  } bpcl_card_e;

  // gray along the usual startup path
  typedef enum logic [3:0] {
    ST_SETTLE      = 4'h0,
    ST_EVAL        = 4'h1,
    ST_COPY_OUT    = 4'h3,
    ST_ERASE       = 4'h2,
    ST_HALT_ERASED = 4'h6,
    ST_COPY_IN     = 4'h7,
    ST_HALT_XFER   = 4'h5,
    ST_RUN_STORE   = 4'h4,
    ST_RUN_CARD    = 4'hc,
    ST_EMPTY_FLASH = 4'hd,
    ST_NO_PROG     = 4'hf
  } bpcl_state_e;

  typedef struct packed {
    logic stopped_led;
    logic maintenance_indicator;
    logic run_from_store;
    logic run_from_card;
    logic erase_req;
    logic copy_to_card_req;
    logic copy_to_store_req;
  } bpcl_out_s;

endpackage
`default_nettype wire
